// [logic/rtu_pkg.sv]
// constants shared by the rtu slave frame handler
package rtu_pkg;
  // clock and line timing
  localparam int CLK_HZ         = 250_000_000;
  localparam int BAUD           = 9600;
  localparam int BIT_CYCLES     = (CLK_HZ + BAUD - 1) / BAUD;
  localparam int CHAR_BITS_NP   = 10;
  localparam int CHAR_BITS_P    = 11;
  localparam int SILENCE_CHARS  = 3;
  localparam int SIL_BITS_NP    = SILENCE_CHARS * CHAR_BITS_NP;
  localparam int SIL_BITS_P     = SILENCE_CHARS * CHAR_BITS_P;
  localparam int TURNAROUND_MS  = 500;
  localparam int CW             = 24;
  // station addresses
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MAX   = 8'hF7;
  // function codes
  localparam logic [7:0] FC_ILLEGAL = 8'h00;
  localparam logic [7:0] FC_LAST_LO = 8'h08;
  localparam logic [7:0] FC_EXC     = 8'h07;
  localparam logic [7:0] FC_WMULT_C = 8'h0F;
  localparam logic [7:0] FC_WMULT_R = 8'h10;
  localparam logic [7:0] FC_IDENT   = 8'h11;
  localparam logic [7:0] FC_SCRATCH = 8'h43;
  localparam logic [7:0] FC_RSV_LO  = 8'h80;
  // frame lengths, counted in bytes with the check field
  localparam logic [8:0] LEN_SHORT  = 9'h004;
  localparam logic [8:0] LEN_FIXED  = 9'h008;
  localparam logic [8:0] LEN_MULTI  = 9'h009;
  localparam logic [8:0] LEN_OPEN   = 9'h1FF;
  localparam logic [8:0] LEN_MIN    = 9'h004;
  localparam logic [8:0] BC_IDX     = 9'h006;
  // error check
  localparam logic [15:0] CRC_INIT  = 16'hFFFF;
  localparam logic [15:0] CRC_POLY  = 16'hA001;
  // function classes
  typedef enum logic [1:0] {
    FCL_OK      = 2'h0,
    FCL_ILLEGAL = 2'h1,
    FCL_UNSUP   = 2'h2,
    FCL_RSV     = 2'h3
  } fclass_t;
endpackage

// [logic/pair_fifo.sv]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module pair_fifo #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // filling side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // draining side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic         wp_q, wp_d, rp_q, rp_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         push, pop;

  // honest full and empty flags
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and occupancy update
  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d        = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  // storage registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// [logic/rtu_slave_frame_handler.sv]
// rtu slave frame handler: serial receive, framing, check field and reply transmit
`timescale 1ns/100ps
module rtu_slave_frame_handler #(
  parameter int BIT_CYCLES = rtu_pkg::BIT_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // serial line
  input  wire logic       rxd,
  output logic            txd,
  // configuration
  input  wire logic [7:0] station_addr,
  input  wire logic       parity_en,
  input  wire logic       parity_odd,
  // received frame bytes
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  // frame end report
  output logic            frame_done,
  output logic            frame_good,
  output logic            frame_bcast,
  output logic [7:0]      frame_func,
  output logic [1:0]      func_class,
  // reply bytes without check field
  input  wire logic [7:0] rsp_data,
  input  wire logic       rsp_valid,
  input  wire logic       rsp_last,
  output logic            rsp_ready,
  output logic            rsp_busy
);
  localparam int CW = rtu_pkg::CW;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } rxs_t;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } txs_t;

  typedef enum logic [3:0] {
    PH_USER = 4'h1,
    PH_CRCL = 4'h2,
    PH_CRCH = 4'h4,
    PH_DONE = 4'h8
  } ph_t;

  // one byte through the reflected check register
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ rtu_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // bit timing limits
  logic [CW-1:0] bit_lim, half_lim, sil_lim;
  assign bit_lim  = CW'(BIT_CYCLES - 1);
  assign half_lim = CW'(BIT_CYCLES / 2 - 1);
  assign sil_lim  = parity_en ? CW'(rtu_pkg::SIL_BITS_P * BIT_CYCLES)
                              : CW'(rtu_pkg::SIL_BITS_NP * BIT_CYCLES);

  // ---- character receiver ----
  rxs_t          rs_q, rs_d;
  logic [CW-1:0] rc_q, rc_d;
  logic [2:0]    ri_q, ri_d;
  logic [7:0]    rsh_q, rsh_d;
  logic          rpe_q, rpe_d;
  logic          rbyte_v, rerr;

  // mid-bit sampling of start, data, parity and stop
  always_comb begin
    rs_d    = rs_q;
    rc_d    = rc_q + CW'(1);
    ri_d    = ri_q;
    rsh_d   = rsh_q;
    rpe_d   = rpe_q;
    rbyte_v = 1'b0;
    rerr    = 1'b0;
    case (rs_q)
      RX_IDLE: begin
        rc_d = '0;
        if (!rxd) rs_d = RX_START;
      end
      RX_START: begin
        if (rc_q == half_lim) begin
          rc_d  = '0;
          ri_d  = 3'h0;
          rpe_d = 1'b0;
          rs_d  = rxd ? RX_IDLE : RX_DATA; // glitch rejected
        end
      end
      RX_DATA: begin
        if (rc_q == bit_lim) begin
          rc_d  = '0;
          rsh_d = {rxd, rsh_q[7:1]}; // lsb first
          ri_d  = ri_q + 3'h1;
          if (ri_q == 3'h7) rs_d = parity_en ? RX_PAR : RX_STOP;
        end
      end
      RX_PAR: begin
        if (rc_q == bit_lim) begin
          rc_d  = '0;
          rpe_d = rxd ^ (^rsh_q) ^ parity_odd;
          rs_d  = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rc_q == bit_lim) begin
          rbyte_v = 1'b1;
          rerr    = ~rxd | rpe_q; // stop must be one
          rs_d    = RX_IDLE;
        end
      end
      default: rs_d = RX_IDLE;
    endcase
  end

  // receiver registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rs_q  <= RX_IDLE;
      rc_q  <= '0;
      ri_q  <= 3'h0;
      rsh_q <= 8'h00;
      rpe_q <= 1'b0;
    end else begin
      rs_q  <= rs_d;
      rc_q  <= rc_d;
      ri_q  <= ri_d;
      rsh_q <= rsh_d;
      rpe_q <= rpe_d;
    end
  end

  // ---- frame tracking ----
  logic [8:0]    cnt_q, cnt_d, len_q, len_d, nbytes;
  logic [15:0]   crc_q, crc_d;
  logic [CW-1:0] sil_q, sil_d;
  logic          in_q, in_d, match_q, match_d, bc_q, bc_d, bad_q, bad_d;
  logic          done_q, done_d, good_q, good_d, reply_q, reply_d;
  logic [7:0]    func_q, func_d;
  logic [1:0]    cls_q, cls_d;
  logic          close, push_v, push_rdy, multi, tx_end;

  assign multi  = (func_q == rtu_pkg::FC_WMULT_C) || (func_q == rtu_pkg::FC_WMULT_R);
  assign push_v = rbyte_v & match_d; // only own or broadcast frames

  // byte count, check, length and silence
  always_comb begin
    cnt_d   = cnt_q;
    crc_d   = crc_q;
    len_d   = len_q;
    sil_d   = sil_q;
    in_d    = in_q;
    match_d = match_q;
    bc_d    = bc_q;
    bad_d   = bad_q;
    func_d  = func_q;
    cls_d   = cls_q;
    good_d  = good_q;
    reply_d = reply_q;
    done_d  = 1'b0;
    close   = 1'b0;
    nbytes  = cnt_q;
    if (tx_end) reply_d = 1'b0;
    if (rbyte_v) begin
      nbytes = cnt_q + 9'h001;
      cnt_d  = nbytes;
      sil_d  = '0;
      in_d   = 1'b1;
      if (cnt_q == 9'h000) begin
        crc_d   = crc_step(rtu_pkg::CRC_INIT, rsh_q); // preset
        bc_d    = (rsh_q == rtu_pkg::ADDR_BCAST);
        match_d = bc_d || ((rsh_q == station_addr) && (rsh_q <= rtu_pkg::ADDR_MAX));
        bad_d   = rerr;
        len_d   = rtu_pkg::LEN_OPEN;
        reply_d = 1'b0; // half duplex: new query voids a reply
      end else begin
        crc_d = crc_step(crc_q, rsh_q);
        bad_d = bad_q | rerr;
      end
      if (cnt_q == 9'h001) begin
        func_d = rsh_q;
        if (rsh_q == rtu_pkg::FC_ILLEGAL) begin
          cls_d = rtu_pkg::FCL_ILLEGAL;
        end else if (rsh_q >= rtu_pkg::FC_RSV_LO) begin
          cls_d = rtu_pkg::FCL_RSV;
        end else if (rsh_q <= rtu_pkg::FC_LAST_LO || rsh_q == rtu_pkg::FC_WMULT_C ||
                     rsh_q == rtu_pkg::FC_WMULT_R || rsh_q == rtu_pkg::FC_IDENT ||
                     rsh_q == rtu_pkg::FC_SCRATCH) begin
          cls_d = rtu_pkg::FCL_OK;
        end else begin
          cls_d = rtu_pkg::FCL_UNSUP;
        end
        if (rsh_q == rtu_pkg::FC_EXC || rsh_q == rtu_pkg::FC_IDENT) begin
          len_d = rtu_pkg::LEN_SHORT; // no information field
        end else if (cls_d == rtu_pkg::FCL_OK && rsh_q != rtu_pkg::FC_WMULT_C &&
                     rsh_q != rtu_pkg::FC_WMULT_R) begin
          len_d = rtu_pkg::LEN_FIXED;
        end
      end
      if (cnt_q == rtu_pkg::BC_IDX && multi) begin
        len_d = rtu_pkg::LEN_MULTI + {1'b0, rsh_q}; // byte count field
      end
      if (push_v && !push_rdy) bad_d = 1'b1; // overrun spoils the frame
      if (nbytes == len_d) close = 1'b1;
    end else if (in_q) begin
      sil_d = sil_q + CW'(1);
      if (sil_q == sil_lim) close = 1'b1; // three silent characters
    end
    if (close) begin
      in_d   = 1'b0;
      cnt_d  = 9'h000;
      sil_d  = '0;
      done_d = match_d; // foreign frames report nothing
      good_d = match_d && !bad_d && (crc_d == 16'h0000) && (nbytes >= rtu_pkg::LEN_MIN);
      reply_d = good_d && !bc_d;
    end
  end

  // frame registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q   <= 9'h000;
      crc_q   <= rtu_pkg::CRC_INIT;
      len_q   <= rtu_pkg::LEN_OPEN;
      sil_q   <= '0;
      in_q    <= 1'b0;
      match_q <= 1'b0;
      bc_q    <= 1'b0;
      bad_q   <= 1'b0;
      func_q  <= 8'h00;
      cls_q   <= 2'h0;
      done_q  <= 1'b0;
      good_q  <= 1'b0;
      reply_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      crc_q   <= crc_d;
      len_q   <= len_d;
      sil_q   <= sil_d;
      in_q    <= in_d;
      match_q <= match_d;
      bc_q    <= bc_d;
      bad_q   <= bad_d;
      func_q  <= func_d;
      cls_q   <= cls_d;
      done_q  <= done_d;
      good_q  <= good_d;
      reply_q <= reply_d;
    end
  end

  // bytes pass unchanged, zero-based addresses included
  pair_fifo #(.W(8)) rx_buf (
    .clk       (clk),
    .rst       (rst),
    .in_data   (rsh_q),
    .in_valid  (push_v),
    .in_ready  (push_rdy),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  assign frame_done  = done_q;
  assign frame_good  = good_q;
  assign frame_bcast = bc_q;
  assign frame_func  = func_q;
  assign func_class  = cls_q;

  // ---- reply transmitter ----
  txs_t          ts_q, ts_d;
  ph_t           ph_q, ph_d;
  logic [CW-1:0] tc_q, tc_d;
  logic [2:0]    ti_q, ti_d;
  logic [7:0]    tsh_q, tsh_d;
  logic [15:0]   tcrc_q, tcrc_d;
  logic          txd_q, txd_d;

  // user bytes only while a reply is owed
  assign rsp_ready = reply_q && (ts_q == TX_IDLE) && (ph_q == PH_USER);
  assign rsp_busy  = (ts_q != TX_IDLE) || (ph_q != PH_USER);
  assign txd       = txd_q;

  // byte loading, check append and bit serialising
  always_comb begin
    ts_d   = ts_q;
    ph_d   = ph_q;
    tc_d   = tc_q + CW'(1);
    ti_d   = ti_q;
    tsh_d  = tsh_q;
    tcrc_d = tcrc_q;
    tx_end = 1'b0;
    case (ts_q)
      TX_IDLE: begin
        tc_d = '0;
        ti_d = 3'h0;
        if (ph_q == PH_CRCL) begin
          tsh_d = tcrc_q[7:0]; // check field after all bytes
          ph_d  = PH_CRCH;
          ts_d  = TX_START;
        end else if (ph_q == PH_CRCH) begin
          tsh_d = tcrc_q[15:8];
          ph_d  = PH_DONE;
          ts_d  = TX_START;
        end else if (rsp_valid && rsp_ready) begin
          tsh_d  = rsp_data;
          tcrc_d = crc_step(tcrc_q, rsp_data);
          ts_d   = TX_START;
          if (rsp_last) ph_d = PH_CRCL;
        end else if (!reply_q) begin
          tcrc_d = rtu_pkg::CRC_INIT;
        end
      end
      TX_START: begin
        if (tc_q == bit_lim) begin
          tc_d = '0;
          ts_d = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tc_q == bit_lim) begin
          tc_d = '0;
          ti_d = ti_q + 3'h1;
          if (ti_q == 3'h7) ts_d = parity_en ? TX_PAR : TX_STOP;
        end
      end
      TX_PAR: begin
        if (tc_q == bit_lim) begin
          tc_d = '0;
          ts_d = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tc_q == bit_lim) begin
          ts_d = TX_IDLE; // next byte loads at once
          if (ph_q == PH_DONE) begin
            ph_d   = PH_USER;
            tx_end = 1'b1;
          end
        end
      end
      default: ts_d = TX_IDLE;
    endcase
    case (ts_d)
      TX_START: txd_d = 1'b0;
      TX_DATA:  txd_d = tsh_d[ti_d]; // lsb first
      TX_PAR:   txd_d = (^tsh_d) ^ parity_odd;
      default:  txd_d = 1'b1; // stop and idle
    endcase
  end

  // transmitter registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ts_q   <= TX_IDLE;
      ph_q   <= PH_USER;
      tc_q   <= '0;
      ti_q   <= 3'h0;
      tsh_q  <= 8'h00;
      tcrc_q <= rtu_pkg::CRC_INIT;
      txd_q  <= 1'b1;
    end else begin
      ts_q   <= ts_d;
      ph_q   <= ph_d;
      tc_q   <= tc_d;
      ti_q   <= ti_d;
      tsh_q  <= tsh_d;
      tcrc_q <= tcrc_d;
      txd_q  <= txd_d;
    end
  end
endmodule

// [dv/rtu_slave_frame_handler_checker.sv]
// port assertions for the rtu slave frame handler
`timescale 1ns/100ps
module rtu_slave_frame_handler_checker #(
  parameter int BIT_CYCLES = 16
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // serial out
  input wire logic       txd,
  // received bytes
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  // frame report
  input wire logic       frame_done,
  input wire logic       frame_good,
  input wire logic       frame_bcast,
  input wire logic [7:0] frame_func,
  input wire logic [1:0] func_class,
  // reply side
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic       rsp_busy
);
  // class each function code belongs to
  function automatic logic [1:0] cls(input logic [7:0] f);
    if (f == 8'h00) return 2'h1;
    if (f[7]) return 2'h3;
    if (f <= 8'h08 || f == 8'h0F || f == 8'h10 || f == 8'h11 || f == 8'h43) return 2'h0;
    return 2'h2;
  endfunction
  // longest high run on txd allowed while a reply is in flight
  localparam int GAP_MAX = 15 * BIT_CYCLES;
  int hi_run_q, hi_run_d;
  // next high-run count
  always_comb begin
    hi_run_d = (rsp_busy && txd) ? hi_run_q + 1 : 0;
  end
  // high-run register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hi_run_q <= 0;
    end else begin
      hi_run_q <= hi_run_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // transmitter and reply handshake
  line_idle_a: assert property (!rsp_busy |-> txd) else $error("txd low while idle");
  start_bit_a: assert property (rsp_valid && rsp_ready |=> !txd && rsp_busy) else $error("no start bit");
  start_len_a: assert property ($fell(txd) |-> !txd [*8]) else $error("start bit short");
  reply_gap_a: assert property (hi_run_q <= GAP_MAX) else $error("reply gap too long");
  // frame report
  done_pulse_a: assert property (frame_done |=> !frame_done) else $error("done not a pulse");
  bcast_quiet_a: assert property (frame_done && frame_bcast |=> !rsp_ready [*8]) else $error("bcast reply");
  bad_quiet_a: assert property (frame_done && !frame_good |=> !rsp_ready [*8]) else $error("bad reply");
  own_reply_a: assert property (frame_done && frame_good && !frame_bcast |-> ##[1:4] rsp_ready)
    else $error("no reply slot");
  class_map_a: assert property (frame_done |-> func_class == cls(frame_func)) else $error("bad class");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("rx lost");
  // main scenarios
  cover property (frame_done && frame_bcast);
  cover property (frame_done && !frame_good);
  cover property (rsp_valid && rsp_ready);
endmodule
bind rtu_slave_frame_handler rtu_slave_frame_handler_checker #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.clk(clk), .rst(rst),
  .txd(txd),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .frame_done(frame_done),
  .frame_good(frame_good), .frame_bcast(frame_bcast), .frame_func(frame_func), .func_class(func_class),
  .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_busy(rsp_busy));

// [dv/rtu_host_model.sv]
// serial host model: sends query characters, collects reply characters
`timescale 1ns/100ps
module rtu_host_model #(
  parameter int BIT_CYCLES = 16
) (
  // clock
  input  wire logic clk,
  // serial line
  output logic      rxd,
  input  wire logic txd,
  // character format
  input  wire logic parity_en,
  input  wire logic parity_odd
);
  logic [7:0] rq[$];
  logic [7:0] b;
  int         perr;
  // one bit, changed just after an edge
  task automatic put_bit(input logic v);
    @(posedge clk);
    #1;
    rxd = v;
    repeat (BIT_CYCLES - 1) @(posedge clk);
  endtask
  // one character on the line
  task automatic send_char(input logic [7:0] c);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) put_bit(c[i]);
    if (parity_en) put_bit(^c ^ parity_odd);
    put_bit(1'b1);
  endtask
  // idle high, then receive reply characters at mid-bit
  initial begin
    rxd = 1'b1;
    perr = 0;
    forever begin
      @(negedge txd);
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge clk);
        b[i] = txd;
      end
      if (parity_en) begin
        repeat (BIT_CYCLES) @(posedge clk);
        if (txd !== (^b ^ parity_odd)) perr++;
      end
      repeat (BIT_CYCLES) @(posedge clk);
      if (txd !== 1'b1) perr++;
      rq.push_back(b);
    end
  end
endmodule

// [dv/rtu_slave_frame_handler_tb_top.sv]
// self-checking bench for the rtu slave frame handler
`timescale 1ns/100ps
module rtu_slave_frame_handler_tb_top;
  localparam int B = 16;
  logic       clk, rst, rxd, txd, parity_en, parity_odd, rx_valid, rx_ready;
  logic       frame_done, frame_good, frame_bcast, rsp_valid, rsp_last, rsp_ready, rsp_busy;
  logic       d_good, d_bcast, hold, skip;
  logic [7:0] station_addr, rx_data, frame_func, rsp_data, d_func, a;
  logic [1:0] func_class;
  logic [7:0] xq[$], q[$];
  logic [7:0] fc8[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h43};
  logic [7:0] fcs[6] = '{8'h00, 8'h0E, 8'h42, 8'h44, 8'h80, 8'hFF};
  int         errors, check_count, dones, seed, n, xn;
  rtu_slave_frame_handler #(.BIT_CYCLES(B)) DUT (.clk(clk), .rst(rst), .rxd(rxd), .txd(txd),
    .station_addr(station_addr), .parity_en(parity_en), .parity_odd(parity_odd), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .frame_done(frame_done), .frame_good(frame_good),
    .frame_bcast(frame_bcast), .frame_func(frame_func), .func_class(func_class), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_ready(rsp_ready), .rsp_busy(rsp_busy));
  rtu_host_model #(.BIT_CYCLES(B)) host (.clk(clk), .rxd(rxd), .txd(txd), .parity_en(parity_en),
    .parity_odd(parity_odd));
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // compare and verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic give_up(input int t);
    if (t >= 4000) begin
      errors++;
      summarize();
    end
  endtask
  function automatic logic [7:0] r();
    return 8'($random(seed));
  endfunction
  // reference check value, reflected, shift right
  function automatic logic [15:0] crc16(input logic [7:0] m[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (m[i]) begin
      c = c ^ {8'h00, m[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // rx stream against the model, frame report capture
  always @(negedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1 && !skip) begin
      xn = xq.size();
      check({xn > 0, rx_data}, {1'b1, (xn > 0) ? xq.pop_front() : 8'h00});
    end
    if (frame_done === 1'b1) begin
      dones++;
      d_good = frame_good;
      d_bcast = frame_bcast;
      d_func = frame_func;
    end
  end
  // random pop pressure
  always @(posedge clk) begin
    #1;
    rx_ready = !hold && ($random(seed) % 3 != 0);
  end
  // one frame with its check field; matching bytes join the model stream
  task automatic frame(input logic [7:0] m[$], input logic spoil);
    logic [15:0] c;
    c = crc16(m) ^ {15'h0, spoil};
    m.push_back(c[7:0]);
    m.push_back(c[15:8]);
    if (m[0] == station_addr || m[0] == 8'h00) foreach (m[i]) xq.push_back(m[i]);
    foreach (m[i]) host.send_char(m[i]);
  endtask
  task automatic run(input logic [7:0] m[$], input logic spoil, input logic [1:0] gb);
    int t;
    n = dones;
    frame(m, spoil);
    for (t = 0; dones == n && t < 4000; t++) @(negedge clk);
    give_up(t);
    check({d_good, d_bcast}, gb);
    check(d_func, m[1]);
  endtask
  // reply bytes through the handshake, then the line result
  task automatic reply(input logic [7:0] m[$]);
    logic [15:0] c;
    int t;
    c = crc16(m);
    host.rq.delete();
    @(posedge clk);
    #1;
    foreach (m[i]) begin
      rsp_valid = 1'b1;
      rsp_data = m[i];
      rsp_last = (i == m.size() - 1);
      for (t = 0; rsp_ready !== 1'b1 && t < 4000; t++) @(negedge clk);
      give_up(t);
      @(posedge clk);
      #1;
    end
    rsp_valid = 1'b0;
    m.push_back(c[7:0]);
    m.push_back(c[15:8]);
    for (t = 0; host.rq.size() < m.size() && t < 4000; t++) @(negedge clk); // host bounded turnaround
    give_up(t);
    foreach (m[i]) check(host.rq[i], m[i]);
    repeat (B) @(negedge clk);
    check({rsp_busy, rsp_ready}, 2'h0);
  endtask
  // main sequence
  initial begin
    seed = 32'hd6cdad18;
    errors = 0;
    check_count = 0;
    dones = 0;
    {hold, skip, parity_en, parity_odd, rsp_valid, rsp_last, rx_ready} = 7'h00;
    rsp_data = 8'h00;
    a = 8'($unsigned($random(seed)) % 247 + 1);
    station_addr = a;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    run({a, 8'h07}, 1'b0, 2'h2);
    reply({a, 8'h07, r()});
    run({a, 8'h11}, 1'b0, 2'h2);
    foreach (fc8[i]) run({a, fc8[i], 8'h00, r(), 8'h00, r()}, 1'b0, 2'h2);
    for (int i = 0; i < 2; i++) begin
      q = {a, 8'h0F + 8'(i), 8'h00, r(), 8'h00, 8'h10, 8'(2 * i)};
      repeat (2 * i) q.push_back(r());
      run(q, 1'b0, 2'h2);
    end
    reply({a, 8'h10, 8'h00, 8'h01});
    foreach (fcs[i]) run({a, fcs[i], r(), r()}, 1'b0, 2'h2);
    $display("test function table done");
    run({8'h00, 8'h06, 8'h00, r(), r(), r()}, 1'b0, 2'h3);
    repeat (20) @(negedge clk);
    check(rsp_ready, 1'b0);
    run({a, 8'h07}, 1'b1, 2'h0);
    n = dones;
    frame({8'(a + 1), 8'h07}, 1'b0);
    repeat (700) @(negedge clk);
    check({dones[7:0], rx_valid}, {n[7:0], 1'b0});
    $display("test broadcast bad foreign done");
    // even parity first, then odd parity
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      #1;
      parity_en = 1'b1;
      parity_odd = p[0];
      run({a, 8'h07}, 1'b0, 2'h2);
      reply({a, 8'h07, r()});
    end
    parity_en = 1'b0;
    check(host.perr, 0);
    $display("test parity done");
    hold = 1'b1;
    skip = 1'b1;
    run({a, 8'h03, r(), r(), r(), r()}, 1'b0, 2'h0);
    check(rx_valid, 1'b1);
    hold = 1'b0;
    for (int t = 0; rx_valid !== 1'b0 && t < 100; t++) @(negedge clk);
    check(rx_valid, 1'b0);
    xq.delete();
    skip = 1'b0;
    $display("test stall done");
    summarize();
  end
endmodule
